// file: hdl/pmcr_top.sv
// Serial-bus configuration register of the power monitor
// Behaviour
// - Host configures device over two-wire bus; settings drive output select, gains, enable.
// - Power-enable bit 6 at zero puts the device in disabled low-power state.
// - Writing one to the power-enable bit returns the device to active operation.
// - General call enable or disable command also enables or disables the device.
// - Bits 5:4 select output: bus voltage, shunt voltage, supply power, load power.
// - Supply power mode takes bus voltage from the supply-side input.
// - Load power mode takes bus voltage from the load-side input.
// - Bits 3:2 select shunt gain 20, 128 or 300 V/V.
// - Power-on value: enabled, supply power, gain 20, attenuation 1/5, rest zero.
// - Bits 1:0 select bus attenuation 2/5, 1/5 or 1/10.
// - Bus voltage output mode always senses at the supply-side input.
`timescale 1ns/100ps
module pmcr_top
#(
  parameter logic [6:0] DEV_ADDR = pmcr_pkg::DEV_ADDR_DEF
)
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   scl,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  output pmcr_pkg::pmcr_cfg_type      cfg,
  output logic                        active,
  output logic                        bus_sense_load
);

  logic [1:0]               pins_s;
  logic                     scl_s;
  logic                     sda_s;
  logic                     scl_d_reg;
  logic                     scl_d_next;
  logic                     sda_d_reg;
  logic                     sda_d_next;
  logic                     start_cond;
  logic                     stop_cond;
  logic                     scl_rise;
  logic                     scl_fall;

  pmcr_pkg::pmcr_state_type state_reg;
  pmcr_pkg::pmcr_state_type state_next;
  pmcr_pkg::pmcr_kind_type  kind_reg;
  pmcr_pkg::pmcr_kind_type  kind_next;
  logic [3:0]               cnt_reg;
  logic [3:0]               cnt_next;
  logic [7:0]               shift_reg;
  logic [7:0]               shift_next;
  logic [7:0]               ptr_reg;
  logic [7:0]               ptr_next;
  logic [7:0]               hi_reg;
  logic [7:0]               hi_next;
  logic                     rw_reg;
  logic                     rw_next;
  logic [15:0]              tx_reg;
  logic [15:0]              tx_next;
  logic                     half_reg;
  logic                     half_next;
  logic                     oe_reg;
  logic                     oe_next;
  pmcr_pkg::pmcr_cfg_type   cfg_reg;
  pmcr_pkg::pmcr_cfg_type   cfg_next;
  logic [15:0]              read_word;
  logic [15:0]              write_word;

  pmcr_sync u_sync
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({scl, sda_in}),
    .sync_out (pins_s)
  );

  assign scl_s      = pins_s[1];
  assign sda_s      = pins_s[0];
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;

  // Unused upper bits read as zero and a foreign pointer reads all zero
  assign read_word  = (ptr_reg == pmcr_pkg::CFG_PTR) ? {9'h000, cfg_reg} : 16'h0000;
  assign write_word = {hi_reg, shift_reg};

  always_comb
  begin
    scl_d_next = scl_s;
    sda_d_next = sda_s;
    state_next = state_reg;
    kind_next  = kind_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    ptr_next   = ptr_reg;
    hi_next    = hi_reg;
    rw_next    = rw_reg;
    tx_next    = tx_reg;
    half_next  = half_reg;
    oe_next    = oe_reg;
    cfg_next   = cfg_reg;
    if (stop_cond)
    begin
      state_next = pmcr_pkg::ST_IDLE;
      oe_next    = 1'b0;
    end
    else if (start_cond)
    begin
      // A repeated start keeps the pointer so a read can follow a pointer write
      state_next = pmcr_pkg::ST_RX;
      kind_next  = pmcr_pkg::K_ADDR;
      cnt_next   = 4'h0;
      rw_next    = 1'b0;
      oe_next    = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        pmcr_pkg::ST_IDLE:
        begin
          oe_next = 1'b0;
        end
        pmcr_pkg::ST_RX:
        begin
          if (scl_rise && cnt_reg != pmcr_pkg::BITS_PER_BYTE)
          begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == pmcr_pkg::BITS_PER_BYTE)
          begin
            state_next = pmcr_pkg::ST_ACK;
            oe_next    = 1'b1;
            unique case (kind_reg)
              pmcr_pkg::K_ADDR:
              begin
                if (shift_reg[7:1] == DEV_ADDR)
                begin
                  rw_next   = shift_reg[0];
                  kind_next = shift_reg[0] ? pmcr_pkg::K_ADDR : pmcr_pkg::K_PTR;
                  tx_next   = read_word;
                  half_next = 1'b0;
                end
                else if (shift_reg == pmcr_pkg::GC_ADDR)
                begin
                  kind_next = pmcr_pkg::K_GC;
                end
                else
                begin
                  // Not addressed: stay off the bus until the next start
                  state_next = pmcr_pkg::ST_IDLE;
                  oe_next    = 1'b0;
                end
              end
              pmcr_pkg::K_PTR:
              begin
                ptr_next  = shift_reg;
                kind_next = pmcr_pkg::K_MSB;
              end
              pmcr_pkg::K_MSB:
              begin
                hi_next   = shift_reg;
                kind_next = pmcr_pkg::K_LSB;
              end
              pmcr_pkg::K_LSB:
              begin
                // Only bits 6:0 are stored; upper bits of the word are dropped
                if (ptr_reg == pmcr_pkg::CFG_PTR)
                begin
                  cfg_next = pmcr_pkg::pmcr_cfg_type'(write_word[pmcr_pkg::CFG_USED-1:0]);
                end
                kind_next = pmcr_pkg::K_MSB;
              end
              pmcr_pkg::K_GC:
              begin
                if (shift_reg == pmcr_pkg::GC_ENABLE)
                begin
                  cfg_next.enable = 1'b1;
                end
                else if (shift_reg == pmcr_pkg::GC_DISABLE)
                begin
                  cfg_next.enable = 1'b0;
                end
              end
              default:
              begin
                state_next = pmcr_pkg::ST_IDLE;
                oe_next    = 1'b0;
              end
            endcase
          end
        end
        pmcr_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            cnt_next = 4'h0;
            if (rw_reg)
            begin
              state_next = pmcr_pkg::ST_TX;
              oe_next    = ~tx_reg[15];
            end
            else
            begin
              state_next = pmcr_pkg::ST_RX;
              oe_next    = 1'b0;
            end
          end
        end
        pmcr_pkg::ST_TX:
        begin
          if (scl_rise)
          begin
            cnt_next = cnt_reg + 4'h1;
          end
          else if (scl_fall)
          begin
            tx_next = {tx_reg[14:0], 1'b0};
            if (cnt_reg == pmcr_pkg::BITS_PER_BYTE)
            begin
              state_next = pmcr_pkg::ST_TX_ACK;
              half_next  = ~half_reg;
              oe_next    = 1'b0;
            end
            else
            begin
              oe_next = ~tx_reg[14];
            end
          end
        end
        pmcr_pkg::ST_TX_ACK:
        begin
          if (scl_rise && sda_s)
          begin
            state_next = pmcr_pkg::ST_IDLE;
          end
          else if (scl_fall)
          begin
            cnt_next   = 4'h0;
            state_next = pmcr_pkg::ST_TX;
            // Word fully sent: reload so repeated reads return fresh state
            if (!half_reg)
            begin
              tx_next = read_word;
              oe_next = ~read_word[15];
            end
            else
            begin
              oe_next = ~tx_reg[15];
            end
          end
        end
        default:
        begin
          state_next = pmcr_pkg::ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= pmcr_pkg::ST_IDLE;
      kind_reg  <= pmcr_pkg::K_ADDR;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg   <= pmcr_pkg::CFG_PTR;
      hi_reg    <= 8'h00;
      rw_reg    <= 1'b0;
      tx_reg    <= 16'h0000;
      half_reg  <= 1'b0;
      oe_reg    <= 1'b0;
      cfg_reg   <= pmcr_pkg::pmcr_cfg_type'(pmcr_pkg::CFG_RESET[pmcr_pkg::CFG_USED-1:0]);
    end
    else
    begin
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
      state_reg <= state_next;
      kind_reg  <= kind_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg   <= ptr_next;
      hi_reg    <= hi_next;
      rw_reg    <= rw_next;
      tx_reg    <= tx_next;
      half_reg  <= half_next;
      oe_reg    <= oe_next;
      cfg_reg   <= cfg_next;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out        = 1'b0;
  assign sda_oe         = oe_reg;
  assign cfg            = cfg_reg;
  assign active         = cfg_reg.enable;
  // Bus voltage sensing leaves the supply side only in load power mode
  assign bus_sense_load = (cfg_reg.signal_select == pmcr_pkg::SEL_LOAD_PWR);

endmodule

// file: hdl/pmcr_pkg.sv
// Constants and types shared by the configuration register block
package pmcr_pkg;

  // Configuration word layout and power-on value
  localparam logic [15:0] CFG_RESET    = 16'h0061;
  localparam int          CFG_USED     = 7;
  localparam int          EN_BIT       = 6;
  localparam int          SEL_LSB      = 4;
  localparam int          GAIN_LSB     = 2;
  localparam int          ATT_LSB      = 0;

  // Serial side: register pointer of the one register, general call codes
  localparam logic [7:0]  CFG_PTR      = 8'h00;
  localparam logic [7:0]  GC_ADDR      = 8'h00;
  localparam logic [7:0]  GC_ENABLE    = 8'h0a;
  localparam logic [7:0]  GC_DISABLE   = 8'h0b;
  localparam logic [6:0]  DEV_ADDR_DEF = 7'h40;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam int          SYNC_WIDTH   = 2;

  typedef enum logic [1:0] {
    SEL_BUS        = 2'b00,
    SEL_SHUNT      = 2'b01,
    SEL_SUPPLY_PWR = 2'b10,
    SEL_LOAD_PWR   = 2'b11
  } pmcr_sel_type;

  typedef enum logic [1:0] {
    GAIN_20   = 2'b00,
    GAIN_128  = 2'b01,
    GAIN_300  = 2'b10,
    GAIN_RSVD = 2'b11
  } pmcr_gain_type;

  typedef enum logic [1:0] {
    ATT_2_5  = 2'b00,
    ATT_1_5  = 2'b01,
    ATT_1_10 = 2'b10,
    ATT_RSVD = 2'b11
  } pmcr_att_type;

  // Bit order matches bits 6..0 of the configuration word
  typedef struct packed {
    logic          enable;
    pmcr_sel_type  signal_select;
    pmcr_gain_type shunt_gain;
    pmcr_att_type  bus_attenuation;
  } pmcr_cfg_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_ACK    = 3'b010,
    ST_TX     = 3'b011,
    ST_TX_ACK = 3'b100
  } pmcr_state_type;

  typedef enum logic [2:0] {
    K_ADDR = 3'b000,
    K_PTR  = 3'b001,
    K_MSB  = 3'b010,
    K_LSB  = 3'b011,
    K_GC   = 3'b100
  } pmcr_kind_type;

endpackage

// file: hdl/pmcr_sync.sv
// Two-flop synchroniser for the serial bus pins
`timescale 1ns/100ps
module pmcr_sync
(
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  input  wire logic [pmcr_pkg::SYNC_WIDTH-1:0] async_in,
  output logic      [pmcr_pkg::SYNC_WIDTH-1:0] sync_out
);

  logic [pmcr_pkg::SYNC_WIDTH-1:0] meta_reg;
  logic [pmcr_pkg::SYNC_WIDTH-1:0] meta_next;
  logic [pmcr_pkg::SYNC_WIDTH-1:0] sync_reg;
  logic [pmcr_pkg::SYNC_WIDTH-1:0] sync_next;

  // Idle bus level is high, so reset to ones to avoid a false start
  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

// file: bench/pmcr_props.sv
// Port checks for the configuration register
`timescale 1ns/100ps
module pmcr_props
(
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   scl,
  input wire logic                   sda_in,
  input wire logic                   sda_out,
  input wire logic                   sda_oe,
  input wire pmcr_pkg::pmcr_cfg_type cfg,
  input wire logic                   active,
  input wire logic                   bus_sense_load
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_reset_cfg_value: assert property ($fell(rst) |-> cfg == pmcr_pkg::CFG_RESET[6:0])
    else $error("cfg not at power-on value");
  chk_reset_outs_idle: assert property ($fell(rst) |-> !sda_oe && active && !bus_sense_load)
    else $error("outputs not idle after reset");
  chk_active_follows_en: assert property (active == cfg.enable)
    else $error("active does not follow enable");
  chk_load_sense_decode: assert property (bus_sense_load == (cfg.signal_select == pmcr_pkg::SEL_LOAD_PWR))
    else $error("bus sense side wrong");
  chk_sda_open_drain: assert property (!sda_out)
    else $error("sda driven high");
  chk_cfg_scl_low: assert property ($changed(cfg) |-> !scl)
    else $error("cfg changed while scl high");
  chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("sda changed while scl high");
  chk_cfg_holds_word: assert property ($changed(cfg) |=> $stable(cfg) [*3])
    else $error("cfg did not hold");
endmodule
bind pmcr_top pmcr_props pmcr_props_inst (.sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg), .active(active), .bus_sense_load(bus_sense_load));

// file: bench/pmcr_host.sv
// Serial bus host model that configures the device
`timescale 1ns/100ps
module pmcr_host
(
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Six cycles a phase keeps each scl level well above four clocks
  task automatic half();
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask
  // Data moves only while scl is low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    half();
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
    half();
  endtask
  // Eight data bits then the acknowledge bit, MSB first
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int k = 8; k >= 0; k--)
      bit_io(d[k], q[k]);
  endtask
endmodule

// file: bench/power_monitor_config_register_bench.sv
// Self-checking bench for the configuration register
`timescale 1ns/100ps
module power_monitor_config_register_bench;
  localparam logic [7:0] DA_W = {pmcr_pkg::DEV_ADDR_DEF, 1'b0};
  logic                   sys_clk;
  logic                   rst;
  wire                    scl;
  wire                    sda_low;
  wire                    sda;
  logic                   sda_out;
  logic                   sda_oe;
  pmcr_pkg::pmcr_cfg_type cfg;
  logic                   active;
  logic                   bus_sense_load;
  int                     n_fail;
  int                     n_tests;
  int                     cyc;
  logic [15:0]            m;
  logic [31:0]            x;
  logic [15:0]            w;
  logic                   ak;
  // Pull-up: the wire is low while either party pulls it
  assign sda = !((sda_oe && !sda_out) || sda_low);
  pmcr_top pmcr_top_inst (.sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .cfg(cfg), .active(active), .bus_sense_load(bus_sense_load));
  pmcr_host pmcr_host_inst (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_out();
    chk({9'h000, cfg}, m);
    chk({15'h0000, active}, {15'h0000, m[6]});
    chk({15'h0000, bus_sense_load}, {15'h0000, m[5:4] == 2'b11});
  endtask
  // n counts bytes after the address: pointer, then high, then low
  task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [15:0] d, input int n, output logic k);
    logic [8:0] q;
    pmcr_host_inst.start();
    pmcr_host_inst.xfer({a, 1'b1}, q);
    k = !q[0];
    if (n > 0) pmcr_host_inst.xfer({p, 1'b1}, q);
    if (n > 1) pmcr_host_inst.xfer({d[15:8], 1'b1}, q);
    if (n > 2) pmcr_host_inst.xfer({d[7:0], 1'b1}, q);
    pmcr_host_inst.stop();
  endtask
  task automatic rd_chk(input logic [15:0] e);
    logic [8:0] a;
    logic [8:0] b;
    pmcr_host_inst.start();
    pmcr_host_inst.xfer({DA_W[7:1], 2'b11}, a);
    pmcr_host_inst.xfer(9'h1fe, a);
    pmcr_host_inst.xfer(9'h1ff, b);
    pmcr_host_inst.stop();
    chk({a[8:1], b[8:1]}, e);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Whole run is about 20500 cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_fail++;
      finish_test();
    end
  end
  initial
  begin
    rst = 1'b1;
    n_fail = 0;
    n_tests = 0;
    x = 32'hca6e;
    m = 16'h0061;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    cmp_out();
    rd_chk(m);
    for (int i = 0; i < 9; i++)
    begin
      x = xs(x);
      w = x[15:0];
      w[5:4] = i[1:0];
      w[3:2] = 2'(i % 3);
      w[1:0] = 2'(i / 3);
      wr(DA_W, pmcr_pkg::CFG_PTR, w, 3, ak);
      m = w & 16'h007f;
      cmp_out();
      rd_chk(m);
    end
    for (int i = 0; i < 3; i++)
    begin
      w[7:0] = (i == 0) ? pmcr_pkg::GC_DISABLE : (i == 1) ? 8'h55 : pmcr_pkg::GC_ENABLE;
      wr(8'h00, w[7:0], 16'h0000, 1, ak);
      if (i != 1) m[6] = (i == 2);
      chk({15'h0000, ak}, 16'h0001);
      cmp_out();
    end
    // Output treated as invalid while the analog side recovers
    repeat (4000) @(posedge sys_clk);
    wr(8'h26, pmcr_pkg::CFG_PTR, 16'h0000, 3, ak);
    chk({15'h0000, ak}, 16'h0000);
    cmp_out();
    wr(DA_W, pmcr_pkg::CFG_PTR, 16'h0000, 2, ak);
    cmp_out();
    wr(DA_W, 8'h05, 16'h0000, 3, ak);
    cmp_out();
    rd_chk(16'h0000);
    wr(DA_W, pmcr_pkg::CFG_PTR, 16'h0000, 1, ak);
    rd_chk(m);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    m = 16'h0061;
    repeat (3) @(posedge sys_clk);
    cmp_out();
    rd_chk(m);
    finish_test();
  end
endmodule
